// file: shared/tcc_pkg.sv
// shared constants, types and helpers of the timer capture/compare block
package tcc_pkg;

	// ==================== bus and register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_TIMER      = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SET_CMP    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RESET_CMP  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_SET_EN     = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_RESET_EN   = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CAPTURE    = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_OUTPUTS    = 8'h28;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==================== field layout
	localparam int NUM_OUT       = 4;
	localparam int CTRL_PRE_LSB  = 0;
	localparam int CTRL_RUN_BIT  = 2;
	localparam int CTRL_RISE_BIT = 3;
	localparam int CTRL_FALL_BIT = 4;
	localparam int CTRL_W        = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h0C;
	localparam int IRQ_CAPTURE   = 0;
	localparam int IRQ_SET_MATCH = 1;
	localparam int IRQ_RST_MATCH = 2;
	localparam int IRQ_OVERFLOW  = 3;
	localparam int IRQ_W         = 4;

	// ==================== timing
	localparam int CLK_MHZ     = 100;
	localparam int TICK_NS     = 1000;
	localparam int CLK_PER_NS  = 1000 / CLK_MHZ;
	localparam int TICK_CYC    = TICK_NS / CLK_PER_NS;
	localparam int PRE_W       = 10;

	typedef enum logic [1:0] {
		TCC_DIV1,
		TCC_DIV2,
		TCC_DIV4,
		TCC_DIV8
	} tcc_div_e;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [3:0]        strb;
	} tcc_wcmd_s;

	typedef struct packed {
		logic [15:0] count;
		logic        stepped;
		logic        wrapped;
	} tcc_time_s;

	function automatic logic tcc_reg_known(input logic [ADDR_W-1:0] a, input logic is_write);
		logic ok;
		ok = (a[1:0] == 2'h0) && (a <= OFS_OUTPUTS);
		if (!is_write && a == OFS_IRQ_CLEAR) begin
			ok = 1'b1;
		end
		return ok;
	endfunction

	function automatic logic [DATA_W-1:0] tcc_merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

// file: design/tcc_timebase.sv
// prescaler and free running 16-bit timer
`timescale 1ns/1ps
module tcc_timebase (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             run,
	input  wire tcc_pkg::tcc_div_e div,
	input  wire logic             pre_restart,
	output tcc_pkg::tcc_time_s    tm
);
	import tcc_pkg::*;

	logic [PRE_W-1:0] pre_cnt;
	logic [PRE_W-1:0] next_pre_cnt;
	tcc_time_s        next_tm;
	logic [PRE_W-1:0] pre_last;

	// ==================== prescaler and counter
	always_comb begin
		pre_last = PRE_W'((TICK_CYC << div) - 1);
		next_pre_cnt = pre_cnt;
		next_tm = tm;
		next_tm.stepped = 1'b0;
		next_tm.wrapped = 1'b0;
		if (pre_restart) begin
			next_pre_cnt = '0;
		end else if (run) begin
			if (pre_cnt >= pre_last) begin
				next_pre_cnt = '0;
				next_tm.count = tm.count + 16'h0001;
				next_tm.stepped = 1'b1;
				next_tm.wrapped = (tm.count == 16'hFFFF);
			end else begin
				next_pre_cnt = pre_cnt + PRE_W'(1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pre_cnt <= '0;
			tm <= '0;
		end else if (ce) begin
			pre_cnt <= next_pre_cnt;
			tm <= next_tm;
		end
	end
endmodule

// file: design/tcc_axil.sv
// axi4-lite slave front end, one write and one read at a time
`timescale 1ns/1ps
module tcc_axil (
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	input  wire logic [tcc_pkg::ADDR_W-1:0] s_axil_awaddr,
	input  wire logic                      s_axil_awvalid,
	output logic                           s_axil_awready,
	input  wire logic [tcc_pkg::DATA_W-1:0] s_axil_wdata,
	input  wire logic [3:0]                s_axil_wstrb,
	input  wire logic                      s_axil_wvalid,
	output logic                           s_axil_wready,
	output logic [1:0]                     s_axil_bresp,
	output logic                           s_axil_bvalid,
	input  wire logic                      s_axil_bready,
	input  wire logic [tcc_pkg::ADDR_W-1:0] s_axil_araddr,
	input  wire logic                      s_axil_arvalid,
	output logic                           s_axil_arready,
	output logic [tcc_pkg::DATA_W-1:0]     s_axil_rdata,
	output logic [1:0]                     s_axil_rresp,
	output logic                           s_axil_rvalid,
	input  wire logic                      s_axil_rready,
	input  wire logic [tcc_pkg::DATA_W-1:0] rd_data,
	output tcc_pkg::tcc_wcmd_s             wcmd
);
	import tcc_pkg::*;

	logic              aw_held, w_held;
	logic [ADDR_W-1:0] aw_q;
	tcc_wcmd_s         next_wcmd;
	logic              next_aw_held, next_w_held, next_awready, next_wready, next_bvalid, next_arready;
	logic              next_rvalid;
	logic [ADDR_W-1:0] next_aw_q;
	logic [DATA_W-1:0] next_rdata;
	logic [1:0]        next_bresp, next_rresp;
	logic              do_write;

	// ==================== channel control
	always_comb begin
		do_write = aw_held && w_held && !s_axil_bvalid;
		next_aw_held = aw_held ? !do_write : (s_axil_awvalid && s_axil_awready);
		next_w_held = w_held ? !do_write : (s_axil_wvalid && s_axil_wready);
		next_aw_q = (s_axil_awvalid && s_axil_awready) ? s_axil_awaddr : aw_q;
		next_wcmd = wcmd;
		next_wcmd.valid = do_write;
		if (s_axil_wvalid && s_axil_wready) begin
			next_wcmd.data = s_axil_wdata;
			next_wcmd.strb = s_axil_wstrb;
		end
		if (do_write) begin
			next_wcmd.addr = aw_q;
		end
		next_bvalid = s_axil_bvalid ? !s_axil_bready : do_write;
		next_bresp = do_write ? (tcc_reg_known(aw_q, 1'b1) ? RESP_OKAY : RESP_SLVERR) : s_axil_bresp;
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		next_rvalid = s_axil_rvalid ? !s_axil_rready : (s_axil_arvalid && s_axil_arready);
		next_arready = !next_rvalid;
		next_rdata = s_axil_rdata;
		next_rresp = s_axil_rresp;
		if (s_axil_arvalid && s_axil_arready) begin
			next_rdata = rd_data;
			next_rresp = tcc_reg_known(s_axil_araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= '0;
			wcmd <= '0;
			s_axil_awready <= 1'b1;
			s_axil_wready <= 1'b1;
			s_axil_bvalid <= 1'b0;
			s_axil_bresp <= RESP_OKAY;
			s_axil_arready <= 1'b1;
			s_axil_rvalid <= 1'b0;
			s_axil_rdata <= '0;
			s_axil_rresp <= RESP_OKAY;
		end else if (ce) begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_q <= next_aw_q;
			wcmd <= next_wcmd;
			s_axil_awready <= next_awready;
			s_axil_wready <= next_wready;
			s_axil_bvalid <= next_bvalid;
			s_axil_bresp <= next_bresp;
			s_axil_arready <= next_arready;
			s_axil_rvalid <= next_rvalid;
			s_axil_rdata <= next_rdata;
			s_axil_rresp <= next_rresp;
		end
	end
endmodule

// file: design/tcc_top.sv
// timer capture/compare block with four set-reset outputs and axi4-lite registers
//
// Overview of operation
// - finest tick is one microsecond
// - 16-bit span over 65 ms, prescale lengthens
// - capture edge latches timer value
// - capture sets flag, enabled flag interrupts
// - reset match sets flag, may interrupt
// - reset enable bit gates reset match
// - disabled reset bit leaves output unchanged
// - set enable arms output for set match
// - cleared set enable keeps output level
// - set match flag sticks until software clears
// - new set compare used for later matches
// - set and reset paths independent per output
// - set compare equality gives one-shot pulse
// - reset compare equality gives one-shot pulse
// - capture copied in the same cycle
`timescale 1ns/1ps
module tcc_top (
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic                       ce,
	input  wire logic [tcc_pkg::ADDR_W-1:0] s_axil_awaddr,
	input  wire logic                       s_axil_awvalid,
	output logic                            s_axil_awready,
	input  wire logic [tcc_pkg::DATA_W-1:0] s_axil_wdata,
	input  wire logic [3:0]                 s_axil_wstrb,
	input  wire logic                       s_axil_wvalid,
	output logic                            s_axil_wready,
	output logic [1:0]                      s_axil_bresp,
	output logic                            s_axil_bvalid,
	input  wire logic                       s_axil_bready,
	input  wire logic [tcc_pkg::ADDR_W-1:0] s_axil_araddr,
	input  wire logic                       s_axil_arvalid,
	output logic                            s_axil_arready,
	output logic [tcc_pkg::DATA_W-1:0]      s_axil_rdata,
	output logic [1:0]                      s_axil_rresp,
	output logic                            s_axil_rvalid,
	input  wire logic                       s_axil_rready,
	input  wire logic                       crank_capture_input,
	output logic [tcc_pkg::NUM_OUT-1:0]     setreset_outputs,
	output logic                            irq
);
	import tcc_pkg::*;

	// ==================== declarations
	tcc_wcmd_s          wcmd;
	tcc_time_s          tm;
	logic [DATA_W-1:0]  rd_data;

	logic [CTRL_W-1:0]  ctrl;
	logic [15:0]        set_compare_value;
	logic [15:0]        reset_compare_value;
	logic [NUM_OUT-1:0] set_enable_bits;
	logic [NUM_OUT-1:0] reset_enable_bits;
	logic [15:0]        capture_value_zero;
	logic [IRQ_W-1:0]   timer_irq_flags;
	logic [IRQ_W-1:0]   irq_enable;
	logic               pre_restart;

	logic [CTRL_W-1:0]  next_ctrl;
	logic [15:0]        next_set_compare_value;
	logic [15:0]        next_reset_compare_value;
	logic [NUM_OUT-1:0] next_set_enable_bits;
	logic [NUM_OUT-1:0] next_reset_enable_bits;
	logic [15:0]        next_capture_value_zero;
	logic [IRQ_W-1:0]   next_timer_irq_flags;
	logic [IRQ_W-1:0]   next_irq_enable;
	logic               next_pre_restart;
	logic [NUM_OUT-1:0] next_setreset_outputs;
	logic               next_irq;

	logic               cap_meta, cap_sync, cap_last;
	logic               next_cap_meta, next_cap_sync, next_cap_last;
	logic               cap_edge;
	logic               set_pulse, reset_pulse;
	logic [IRQ_W-1:0]   irq_events;
	logic [IRQ_W-1:0]   irq_clear;

	// ==================== bus slave
	tcc_axil u_axil (
		.mclk           (mclk),
		.rst            (rst),
		.ce             (ce),
		.s_axil_awaddr  (s_axil_awaddr),
		.s_axil_awvalid (s_axil_awvalid),
		.s_axil_awready (s_axil_awready),
		.s_axil_wdata   (s_axil_wdata),
		.s_axil_wstrb   (s_axil_wstrb),
		.s_axil_wvalid  (s_axil_wvalid),
		.s_axil_wready  (s_axil_wready),
		.s_axil_bresp   (s_axil_bresp),
		.s_axil_bvalid  (s_axil_bvalid),
		.s_axil_bready  (s_axil_bready),
		.s_axil_araddr  (s_axil_araddr),
		.s_axil_arvalid (s_axil_arvalid),
		.s_axil_arready (s_axil_arready),
		.s_axil_rdata   (s_axil_rdata),
		.s_axil_rresp   (s_axil_rresp),
		.s_axil_rvalid  (s_axil_rvalid),
		.s_axil_rready  (s_axil_rready),
		.rd_data        (rd_data),
		.wcmd           (wcmd)
	);

	// ==================== time base
	tcc_timebase u_timebase (
		.mclk        (mclk),
		.rst         (rst),
		.ce          (ce),
		.run         (ctrl[CTRL_RUN_BIT]),
		.div         (tcc_div_e'(ctrl[CTRL_PRE_LSB +: 2])),
		.pre_restart (pre_restart),
		.tm          (tm)
	);

	// ==================== capture input
	// the first stage feeds only the second; edges are seen on the later pair
	always_comb begin
		next_cap_meta = crank_capture_input;
		next_cap_sync = cap_meta;
		next_cap_last = cap_sync;
		cap_edge = (ctrl[CTRL_RISE_BIT] && cap_sync && !cap_last)
			|| (ctrl[CTRL_FALL_BIT] && !cap_sync && cap_last);
		next_capture_value_zero = cap_edge ? tm.count : capture_value_zero;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cap_meta <= 1'b0;
			cap_sync <= 1'b0;
			cap_last <= 1'b0;
			capture_value_zero <= '0;
		end else if (ce) begin
			cap_meta <= next_cap_meta;
			cap_sync <= next_cap_sync;
			cap_last <= next_cap_last;
			capture_value_zero <= next_capture_value_zero;
		end
	end

	// ==================== compare and outputs
	// matches fire only on the cycle the timer steps onto the value, so a
	// compare written equal to a held count waits for the next pass
	always_comb begin
		set_pulse = tm.stepped && (tm.count == set_compare_value);
		reset_pulse = tm.stepped && (tm.count == reset_compare_value);
		next_setreset_outputs = setreset_outputs;
		for (int i = 0; i < NUM_OUT; i++) begin
			if (set_pulse && set_enable_bits[i]) begin
				next_setreset_outputs[i] = 1'b1;
			end
			if (reset_pulse && reset_enable_bits[i]) begin
				next_setreset_outputs[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			setreset_outputs <= '0;
		end else if (ce) begin
			setreset_outputs <= next_setreset_outputs;
		end
	end

	// ==================== registers and interrupt flags
	always_comb begin
		next_ctrl = ctrl;
		next_set_compare_value = set_compare_value;
		next_reset_compare_value = reset_compare_value;
		next_set_enable_bits = set_enable_bits;
		next_reset_enable_bits = reset_enable_bits;
		next_irq_enable = irq_enable;
		next_pre_restart = 1'b0;
		irq_clear = '0;
		if (wcmd.valid) begin
			case (wcmd.addr)
				OFS_CTRL: begin
					next_ctrl = CTRL_W'(tcc_merge(DATA_W'(ctrl), wcmd.data, wcmd.strb));
					// any prescale or run change restarts the divider
					next_pre_restart = 1'b1;
				end
				OFS_SET_CMP: begin
					next_set_compare_value = 16'(tcc_merge(DATA_W'(set_compare_value), wcmd.data, wcmd.strb));
				end
				OFS_RESET_CMP: begin
					next_reset_compare_value = 16'(tcc_merge(DATA_W'(reset_compare_value), wcmd.data, wcmd.strb));
				end
				OFS_SET_EN: begin
					next_set_enable_bits = NUM_OUT'(tcc_merge(DATA_W'(set_enable_bits), wcmd.data, wcmd.strb));
				end
				OFS_RESET_EN: begin
					next_reset_enable_bits = NUM_OUT'(tcc_merge(DATA_W'(reset_enable_bits), wcmd.data, wcmd.strb));
				end
				OFS_IRQ_CLEAR: begin
					irq_clear = IRQ_W'(tcc_merge('0, wcmd.data, wcmd.strb));
				end
				OFS_IRQ_ENABLE: begin
					next_irq_enable = IRQ_W'(tcc_merge(DATA_W'(irq_enable), wcmd.data, wcmd.strb));
				end
				default: begin
				end
			endcase
		end
		irq_events = '0;
		irq_events[IRQ_CAPTURE] = cap_edge;
		irq_events[IRQ_SET_MATCH] = set_pulse;
		irq_events[IRQ_RST_MATCH] = reset_pulse;
		irq_events[IRQ_OVERFLOW] = tm.wrapped;
		// a new event in the clearing cycle survives the clear
		next_timer_irq_flags = (timer_irq_flags & ~irq_clear) | irq_events;
		next_irq = |(next_timer_irq_flags & next_irq_enable);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
			set_compare_value <= '0;
			reset_compare_value <= '0;
			set_enable_bits <= '0;
			reset_enable_bits <= '0;
			timer_irq_flags <= '0;
			irq_enable <= '0;
			pre_restart <= 1'b0;
			irq <= 1'b0;
		end else if (ce) begin
			ctrl <= next_ctrl;
			set_compare_value <= next_set_compare_value;
			reset_compare_value <= next_reset_compare_value;
			set_enable_bits <= next_set_enable_bits;
			reset_enable_bits <= next_reset_enable_bits;
			timer_irq_flags <= next_timer_irq_flags;
			irq_enable <= next_irq_enable;
			pre_restart <= next_pre_restart;
			irq <= next_irq;
		end
	end

	// ==================== read mux
	always_comb begin
		rd_data = '0;
		case (s_axil_araddr)
			OFS_CTRL:       rd_data = DATA_W'(ctrl);
			OFS_TIMER:      rd_data = DATA_W'(tm.count);
			OFS_SET_CMP:    rd_data = DATA_W'(set_compare_value);
			OFS_RESET_CMP:  rd_data = DATA_W'(reset_compare_value);
			OFS_SET_EN:     rd_data = DATA_W'(set_enable_bits);
			OFS_RESET_EN:   rd_data = DATA_W'(reset_enable_bits);
			OFS_CAPTURE:    rd_data = DATA_W'(capture_value_zero);
			OFS_IRQ_STATUS: rd_data = DATA_W'(timer_irq_flags);
			OFS_IRQ_ENABLE: rd_data = DATA_W'(irq_enable);
			OFS_OUTPUTS:    rd_data = DATA_W'(setreset_outputs);
			default:        rd_data = '0;
		endcase
	end
endmodule

// file: dv/tcc_engine_model.sv
// crank sensor and injector driver stand-in for the capture/compare block
`timescale 1ns/1ps
module tcc_engine_model (
	input  wire logic                        mclk,
	input  wire logic                        fire,
	input  wire logic [tcc_pkg::NUM_OUT-1:0] setreset_outputs,
	output logic                             crank_capture_input = 1'b0,
	output logic [15:0]                      opens = 16'h0000
);
	import tcc_pkg::*;
	logic [4:0]         hold = 5'h00;
	logic [NUM_OUT-1:0] last = '0;
	// ==================== sensor pulse and injector openings
	// pulse stays high about 20 clocks so both edges pass the pin synchroniser
	always @(posedge mclk) begin
		hold <= fire ? 5'h14 : ((hold != 5'h00) ? hold - 5'h01 : hold);
		crank_capture_input <= fire || (hold > 5'h01);
		last <= setreset_outputs;
		opens <= opens + 16'($countones(setreset_outputs & ~last));
	end
endmodule

// file: dv/tcc_top_assertions.sv
// port checker for the timer capture/compare block
`timescale 1ns/1ps
module tcc_top_assertions (
	input wire logic                        mclk,
	input wire logic                        rst,
	input wire logic [tcc_pkg::ADDR_W-1:0]  s_axil_awaddr,
	input wire logic                        s_axil_awvalid,
	input wire logic                        s_axil_awready,
	input wire logic                        s_axil_wvalid,
	input wire logic                        s_axil_wready,
	input wire logic [1:0]                  s_axil_bresp,
	input wire logic                        s_axil_bvalid,
	input wire logic                        s_axil_bready,
	input wire logic [tcc_pkg::ADDR_W-1:0]  s_axil_araddr,
	input wire logic                        s_axil_arvalid,
	input wire logic                        s_axil_arready,
	input wire logic [tcc_pkg::DATA_W-1:0]  s_axil_rdata,
	input wire logic [1:0]                  s_axil_rresp,
	input wire logic                        s_axil_rvalid,
	input wire logic                        s_axil_rready,
	input wire logic [tcc_pkg::NUM_OUT-1:0] setreset_outputs,
	input wire logic                        irq
);
	import tcc_pkg::*;
	logic aw_take, ar_take, wr_bad, next_wr_bad, en_seen, next_en_seen, arm_seen, next_arm_seen;
	function automatic logic bad_addr(input logic [ADDR_W-1:0] a);
		return (a[1:0] != 2'h0) || (a > OFS_OUTPUTS);
	endfunction
	// ==================== bookkeeping of bus handshakes and writes
	assign aw_take = s_axil_awvalid && s_axil_awready;
	assign ar_take = s_axil_arvalid && s_axil_arready;
	always_comb begin
		next_wr_bad = aw_take ? bad_addr(s_axil_awaddr) : wr_bad;
		next_en_seen = en_seen || (aw_take && s_axil_awaddr == OFS_IRQ_ENABLE);
		next_arm_seen = arm_seen || (aw_take && s_axil_awaddr == OFS_SET_EN);
	end
	always_ff @(posedge mclk) begin
		wr_bad <= rst ? 1'b0 : next_wr_bad;
		en_seen <= rst ? 1'b0 : next_en_seen;
		arm_seen <= rst ? 1'b0 : next_arm_seen;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ==================== bus handshakes
	property p_wr_answer; aw_take && s_axil_wvalid && s_axil_wready |-> ##2 s_axil_bvalid; endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_aw_refused; aw_take |=> !s_axil_awready; endproperty
	a_aw_refused: assert property (p_aw_refused) else $error("address taken twice");
	property p_b_stands; s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp); endproperty
	a_b_stands: assert property (p_b_stands) else $error("write answer dropped");
	property p_wr_resp; s_axil_bvalid |-> s_axil_bresp == (wr_bad ? RESP_SLVERR : RESP_OKAY); endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("wrong write response");
	property p_rd_answer;
		ar_take |=> s_axil_rvalid && s_axil_rresp == (bad_addr($past(s_axil_araddr)) ? RESP_SLVERR : RESP_OKAY);
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("wrong read answer");
	property p_r_stands; s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata); endproperty
	a_r_stands: assert property (p_r_stands) else $error("read answer dropped");
	property p_ar_refused; s_axil_rvalid |-> !s_axil_arready; endproperty
	a_ar_refused: assert property (p_ar_refused) else $error("read taken while busy");
	property p_clear_reads_zero; ar_take && s_axil_araddr == OFS_IRQ_CLEAR |=> s_axil_rdata == 32'h0; endproperty
	a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register reads nonzero");
	// ==================== outputs after reset
	property p_reset_quiet; $fell(rst) |-> setreset_outputs == '0 && !irq; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	property p_irq_gated; !en_seen |-> !irq; endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("interrupt without enable");
	property p_out_armed; !arm_seen |-> setreset_outputs == '0; endproperty
	a_out_armed: assert property (p_out_armed) else $error("output moved before arming");
endmodule
bind tcc_top tcc_top_assertions u_tcc_top_assertions (.*);

// file: dv/tcc_top_tb.sv
// self-checking bench for the timer capture/compare block
`timescale 1ns/1ps
module tcc_top_tb;
	import tcc_pkg::*;
	logic               mclk, rst, ce, crank_capture_input, irq, fire;
	logic               s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid, s_axil_bready;
	logic               s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
	logic [ADDR_W-1:0]  s_axil_awaddr, s_axil_araddr;
	logic [DATA_W-1:0]  s_axil_wdata, s_axil_rdata, v, t;
	logic [3:0]         s_axil_wstrb, se, re, en, exp_out, prev, sts;
	logic [1:0]         s_axil_bresp, s_axil_rresp;
	logic [NUM_OUT-1:0] setreset_outputs;
	logic [15:0]        opens;
	int                 failures = 0, num_checks = 0, seed = 40, exp_opens = 0;

	tcc_top u_tcc_top (.*);
	tcc_engine_model u_tcc_engine_model (.*);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ==================== checking and closing
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	function automatic logic [1:0] resp_of(input logic [ADDR_W-1:0] a);
		return (a[1:0] != 2'h0 || a > OFS_OUTPUTS) ? RESP_SLVERR : RESP_OKAY;
	endfunction
	// ==================== bus master
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		s_axil_awaddr <= a;
		s_axil_wdata <= d;
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 1'b0;
			if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 1'b0;
			if (s_axil_bvalid) break;
		end
		s_axil_bready <= 1'b0;
		chk("bresp", 32'(s_axil_bresp), 32'(resp_of(a)));
		if (n == 50) failures++;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		int n;
		@(posedge mclk);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 1'b0;
			if (s_axil_rvalid) break;
		end
		d = s_axil_rdata;
		s_axil_rready <= 1'b0;
		chk("rresp", 32'(s_axil_rresp), 32'(resp_of(a)));
		if (n == 50) failures++;
	endtask
	// ==================== tests
	initial begin
		{rst, ce, fire, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = 8'hC0;
		{s_axil_awaddr, s_axil_araddr, s_axil_wdata, s_axil_wstrb} = '0;
		s_axil_wstrb = 4'hF;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		for (int a = 0; a <= 40; a += 4) begin
			if (a != 4) begin
				rd(8'(a), v);
				chk("reset value", v, (a == 0) ? 32'(CTRL_RESET) : 32'h0);
			end
		end
		// read-only and unmapped places must not disturb anything
		wr(OFS_OUTPUTS, 32'hF);
		wr(8'h30, 32'hF);
		wr(8'h12, 32'hF);
		rd(8'h2C, v);
		rd(OFS_OUTPUTS, v);
		chk("outputs", v, 32'h0);
		$display("test registers done");
		for (int p = 0; p < 4; p++) begin
			wr(OFS_CTRL, 32'(CTRL_RESET) | p);
			rd(OFS_TIMER, t);
			repeat ((5 * TICK_CYC) << p) @(posedge mclk);
			rd(OFS_TIMER, v);
			chk("ticks", 32'(v - t >= 5 && v - t <= 6), 1);
		end
		wr(OFS_CTRL, 32'(CTRL_RESET));
		// clock enable low must hold the timer through three ticks
		rd(OFS_TIMER, t);
		ce <= 1'b0;
		repeat (3 * TICK_CYC) @(posedge mclk);
		ce <= 1'b1;
		rd(OFS_TIMER, v);
		chk("frozen timer", 32'(v - t <= 1), 1);
		$display("test prescale done");
		exp_out = 4'h0;
		for (int i = 0; i < 8; i++) begin
			se = (i == 0) ? 4'hF : 4'($random(seed));
			re = (i == 0) ? 4'hF : 4'($random(seed));
			en = 4'($random(seed));
			wr(OFS_SET_EN, 32'(se));
			wr(OFS_RESET_EN, 32'(re));
			wr(OFS_IRQ_ENABLE, 32'(en));
			rd(OFS_TIMER, t);
			wr(OFS_SET_CMP, t + 32'd3);
			// first pass lets both compares hit the same timer step
			if (i == 0) wr(OFS_RESET_CMP, t + 32'd3);
			repeat (5 * TICK_CYC) @(posedge mclk);
			prev = exp_out;
			exp_out = (i == 0) ? (exp_out & ~re) : (exp_out | se);
			exp_opens += $countones(exp_out & ~prev);
			sts = (i == 0) ? 4'h6 : 4'h2;
			chk("outputs after set", 32'(setreset_outputs), 32'(exp_out));
			repeat (3 * TICK_CYC) @(posedge mclk);
			rd(OFS_IRQ_STATUS, v);
			chk("set flag", v, 32'(sts));
			chk("irq after set", 32'(irq), 32'(|(sts & en)));
			wr(OFS_IRQ_CLEAR, 32'hF);
			rd(OFS_IRQ_STATUS, v);
			chk("flags cleared", v, 32'h0);
			chk("irq cleared", 32'(irq), 32'h0);
			rd(OFS_TIMER, t);
			wr(OFS_RESET_CMP, t + 32'd3);
			repeat (5 * TICK_CYC) @(posedge mclk);
			exp_out = exp_out & ~re;
			chk("outputs after reset", 32'(setreset_outputs), 32'(exp_out));
			rd(OFS_IRQ_STATUS, v);
			chk("reset flag", v, 32'h4);
			chk("irq after reset", 32'(irq), 32'(en[IRQ_RST_MATCH]));
			wr(OFS_IRQ_CLEAR, 32'hF);
		end
		$display("test compare done");
		for (int m = 0; m < 4; m++) begin
			wr(OFS_CTRL, 32'h4 | (m << CTRL_RISE_BIT));
			wr(OFS_IRQ_ENABLE, 32'h1);
			rd(OFS_TIMER, t);
			@(posedge mclk);
			fire <= 1'b1;
			@(posedge mclk);
			fire <= 1'b0;
			repeat (40) @(posedge mclk);
			rd(OFS_CAPTURE, v);
			chk("capture", 32'((m == 0) ? (v == 32'h0) : (v - t <= 32'h1)), 1);
			rd(OFS_IRQ_STATUS, v);
			chk("capture flag", v, 32'(m != 0));
			chk("capture irq", 32'(irq), 32'(m != 0));
			wr(OFS_IRQ_CLEAR, 32'hF);
		end
		chk("injector opens", 32'(opens), 32'(exp_opens));
		$display("test capture done");
		tally_and_finish();
	end
	// the whole sequence needs about 19k clocks
	initial begin
		#(80000 * 10);
		failures++;
		tally_and_finish();
	end
endmodule
